// file: pkg/ecl_pkg.sv
package ecl_pkg;
  localparam int NERR = 14;
  localparam int CODE_W = 10;
  localparam int IDX_W = 4;
  localparam int CNT_W = 32;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int BLINK_FAST_MS = 100;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_SLOW_MS = 1000;

  // Half a blink period in clock cycles, rounded down
  function automatic int half_cyc(input int ms);
    return (ms * (NS_PER_MS / CLK_PERIOD_NS)) / 2;
  endfunction : half_cyc

  localparam int FAST_HALF_CYC = half_cyc(BLINK_FAST_MS);
  localparam int HALF_HALF_CYC = half_cyc(BLINK_HALF_MS);
  localparam int SLOW_HALF_CYC = half_cyc(BLINK_SLOW_MS);

  typedef enum logic [1:0] {
    BLK_FAST = 2'h0,
    BLK_HALF = 2'h1,
    BLK_SLOW = 2'h2
  } ecl_blink_t;

  // Fault slots
  localparam int E_PGM = 0;
  localparam int E_IOPRM = 1;
  localparam int E_BPRM = 2;
  localparam int E_MISM = 3;
  localparam int E_MODCHG = 4;
  localparam int E_IOACC = 5;
  localparam int E_SPACC = 6;
  localparam int E_CPU = 7;
  localparam int E_WDT = 8;
  localparam int E_OPER = 9;
  localparam int E_TMR = 10;
  localparam int E_EXT = 11;
  localparam int E_ESTOP = 12;
  localparam int E_BACKUP = 13;

  localparam logic [CODE_W-1:0] CODE_PGM = 10'h017;
  localparam logic [CODE_W-1:0] CODE_IOPRM = 10'h018;
  localparam logic [CODE_W-1:0] CODE_BPRM = 10'h019;
  localparam logic [CODE_W-1:0] CODE_MISM = 10'h01e;
  localparam logic [CODE_W-1:0] CODE_MODCHG = 10'h01f;
  localparam logic [CODE_W-1:0] CODE_IOACC = 10'h021;
  localparam logic [CODE_W-1:0] CODE_SPACC = 10'h022;
  localparam logic [CODE_W-1:0] CODE_CPU = 10'h027;
  localparam logic [CODE_W-1:0] CODE_WDT = 10'h028;
  localparam logic [CODE_W-1:0] CODE_OPER = 10'h029;
  localparam logic [CODE_W-1:0] CODE_TMR = 10'h02c;
  localparam logic [CODE_W-1:0] CODE_EXT = 10'h032;
  localparam logic [CODE_W-1:0] CODE_ESTOP = 10'h03c;
  localparam logic [CODE_W-1:0] CODE_BACKUP = 10'h1f4;
  localparam logic [CODE_W-1:0] CODE_NONE = 10'h000;

  localparam logic [CODE_W-1:0] CODE_TAB [NERR] = '{
    CODE_PGM, CODE_IOPRM, CODE_BPRM, CODE_MISM, CODE_MODCHG, CODE_IOACC, CODE_SPACC,
    CODE_CPU, CODE_WDT, CODE_OPER, CODE_TMR, CODE_EXT, CODE_ESTOP, CODE_BACKUP};
  localparam ecl_blink_t BLINK_TAB [NERR] = '{
    BLK_HALF, BLK_HALF, BLK_HALF, BLK_HALF, BLK_FAST, BLK_FAST, BLK_FAST,
    BLK_FAST, BLK_HALF, BLK_HALF, BLK_HALF, BLK_SLOW, BLK_SLOW, BLK_SLOW};
  // Heavy slots: 5, 6, 7, 11, 12
  localparam logic [NERR-1:0] HEAVY_MASK = 14'h18e0;
  // Slots 7, 12, 13 stay until power is cycled
  localparam logic [NERR-1:0] CLR_MASK = 14'h0f7f;
  localparam logic [NERR-1:0] ONE_FLAG = 14'h0001;
endpackage : ecl_pkg

// file: rtl/ecl_flag.sv
`timescale 1ns/1ps
`default_nettype none
module ecl_flag
  import ecl_pkg::*;
#(
  parameter int N = NERR,
  parameter logic [N-1:0] CLR_OK = CLR_MASK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fault conditions and their check points
  input wire logic [N-1:0] cond,
  input wire logic [N-1:0] chk,
  // Operator clear
  input wire logic clr,
  // Latched faults
  output logic [N-1:0] flag
);
  if (N < 1) begin : g_bad_n
    $error("ecl_flag: N must be at least 1");
  end

  // A fault seen at its check point wins over a clear in the same cycle
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        flag[i] <= 1'b0;
      end else if (cond[i] && chk[i]) begin
        flag[i] <= 1'b1;
      end else if (clr && CLR_OK[i]) begin
        flag[i] <= 1'b0;
      end
    end
  end
endmodule : ecl_flag
`default_nettype wire

// file: rtl/ecl_blink.sv
`timescale 1ns/1ps
`default_nettype none
module ecl_blink
  import ecl_pkg::*;
#(
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int HALF_HALF = HALF_HALF_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Blink control
  input wire logic en,
  input wire ecl_blink_t sel,
  // LED drive
  output logic led
);
  if (FAST_HALF < 1 || HALF_HALF < 1 || SLOW_HALF < 1) begin : g_bad_half
    $error("ecl_blink: half periods must be at least one cycle");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] half_m1;
  ecl_blink_t sel_q;
  logic en_q;

  always_comb begin
    case (sel)
      BLK_FAST: half_m1 = CNT_W'(FAST_HALF - 1);
      BLK_SLOW: half_m1 = CNT_W'(SLOW_HALF - 1);
      default: half_m1 = CNT_W'(HALF_HALF - 1);
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= BLK_HALF;
      en_q <= 1'b0;
    end else begin
      sel_q <= sel;
      en_q <= en;
    end
  end

  // A new period or a fresh enable restarts the blink with the LED lit
  always_ff @(posedge clk) begin
    if (rst || !en || !en_q || sel != sel_q) begin
      cnt <= '0;
      led <= en;
    end else if (cnt >= half_m1) begin
      cnt <= '0;
      led <= !led;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_led_toggle: assert property (en && en_q && sel == sel_q && cnt == half_m1 |=> led != $past(led))
    else $error("LED did not toggle at end of half period");
  chk_led_hold: assert property (en && en_q && sel == sel_q && cnt < half_m1 |=> led == $past(led))
    else $error("LED toggled before end of half period");
  chk_led_off: assert property (!en |=> !led)
    else $error("LED lit while no error active");
endmodule : ecl_blink
`default_nettype wire

// file: rtl/ecl_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Corrupt program: code 23, warning, 0.5s, RUN entry
// - Bad I/O parameter: code 24, reset/RUN entry
// - Bad basic parameter: code 25, reset/RUN entry
// - Module type mismatch: code 30, RUN entry
// - Module added/removed: code 31, 0.1s, scan
// - I/O access failure: code 33, heavy, scan end
// - Special/link access failure: code 34, heavy
// - Processor fault: code 39, heavy, always watched
// - Scan watchdog overrun: code 40, while running
// - Operation error: code 41, while running
// - Timer index error: code 44, scan end
// - External heavy fault: code 50, 1s, flag
// - Emergency stop: code 60, cleared by power cycle
// - Backup failure: code 500, power-on, force STOP
module ecl_top
  import ecl_pkg::*;
#(
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int HALF_HALF = HALF_HALF_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Check points
  input wire logic RUN_SWITCH,
  input wire logic CPU_RESET,
  input wire logic SCAN_START,
  input wire logic SCAN_END,
  input wire logic PGM_RUN,
  // Fault conditions
  input wire logic PGM_BAD,
  input wire logic IOPRM_BAD,
  input wire logic BPRM_BAD,
  input wire logic MOD_MISMATCH,
  input wire logic MOD_CHANGE,
  input wire logic IO_ACC_FAIL,
  input wire logic SPL_ACC_FAIL,
  input wire logic CPU_FAULT,
  input wire logic SCAN_OVER,
  input wire logic OPER_ERR,
  input wire logic TMR_IDX_ERR,
  input wire logic EXT_HEAVY,
  input wire logic ESTOP_EXEC,
  input wire logic BACKUP_FAIL,
  // Operator restart
  input wire logic CLR_ERR,
  // Error report
  output logic [CODE_W-1:0] ERR_CODE,
  output logic ERR_HEAVY,
  output logic ERR_ACTIVE,
  output logic ERR_LED,
  output logic [NERR-1:0] ERR_FLAGS,
  output logic EXT_HEAVY_FLAG,
  output logic FORCE_STOP
);
  logic por_chk;
  logic rst_chk;
  logic [NERR-1:0] cond;
  logic [NERR-1:0] chk;
  logic [NERR-1:0] err_flag;
  logic [IDX_W-1:0] next_idx;
  logic next_heavy;
  logic next_any;
  ecl_blink_t blink_sel;

  // Power-on check window is the first cycle after reset release
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      por_chk <= 1'b1;
    end else begin
      por_chk <= 1'b0;
    end
  end

  assign rst_chk = CPU_RESET || por_chk;

  always_comb begin
    cond = '0;
    cond[E_PGM] = PGM_BAD;
    cond[E_IOPRM] = IOPRM_BAD;
    cond[E_BPRM] = BPRM_BAD;
    cond[E_MISM] = MOD_MISMATCH;
    cond[E_MODCHG] = MOD_CHANGE;
    cond[E_IOACC] = IO_ACC_FAIL;
    cond[E_SPACC] = SPL_ACC_FAIL;
    cond[E_CPU] = CPU_FAULT;
    cond[E_WDT] = SCAN_OVER;
    cond[E_OPER] = OPER_ERR;
    cond[E_TMR] = TMR_IDX_ERR;
    cond[E_EXT] = EXT_HEAVY;
    cond[E_ESTOP] = ESTOP_EXEC;
    cond[E_BACKUP] = BACKUP_FAIL;
  end

  // Each fault but the processor fault, which is sampled every cycle, is only sampled at its own check point
  always_comb begin
    chk = '0;
    chk[E_PGM] = RUN_SWITCH;
    chk[E_IOPRM] = RUN_SWITCH || rst_chk;
    chk[E_BPRM] = RUN_SWITCH || rst_chk;
    chk[E_MISM] = RUN_SWITCH;
    chk[E_MODCHG] = SCAN_START;
    chk[E_IOACC] = SCAN_END;
    chk[E_SPACC] = SCAN_END;
    chk[E_CPU] = 1'b1;
    chk[E_WDT] = PGM_RUN;
    chk[E_OPER] = PGM_RUN;
    chk[E_TMR] = SCAN_END;
    chk[E_EXT] = SCAN_END;
    chk[E_ESTOP] = PGM_RUN;
    chk[E_BACKUP] = por_chk;
  end

  ecl_flag #(
    .N(NERR),
    .CLR_OK(CLR_MASK)
  ) u_flag (
    .clk(CLK_SYS),
    .rst(RST),
    .cond(cond),
    .chk(chk),
    .clr(CLR_ERR),
    .flag(err_flag)
  );

  // Heavy errors first, then warnings; lowest slot wins within a class
  always_comb begin
    next_idx = '0;
    next_heavy = 1'b0;
    next_any = |err_flag;
    for (int i = NERR - 1; i >= 0; i--) begin
      if (err_flag[i] && HEAVY_MASK[i]) begin
        next_idx = IDX_W'(i);
        next_heavy = 1'b1;
      end
    end
    if (!next_heavy) begin
      for (int i = NERR - 1; i >= 0; i--) begin
        if (err_flag[i]) begin
          next_idx = IDX_W'(i);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ERR_CODE <= CODE_NONE;
      ERR_HEAVY <= 1'b0;
      ERR_ACTIVE <= 1'b0;
      blink_sel <= BLK_HALF;
    end else begin
      ERR_CODE <= next_any ? CODE_TAB[next_idx] : CODE_NONE;
      ERR_HEAVY <= next_heavy;
      ERR_ACTIVE <= next_any;
      blink_sel <= BLINK_TAB[next_idx];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ERR_FLAGS <= '0;
      EXT_HEAVY_FLAG <= 1'b0;
      FORCE_STOP <= 1'b0;
    end else begin
      ERR_FLAGS <= err_flag;
      EXT_HEAVY_FLAG <= err_flag[E_EXT];
      FORCE_STOP <= err_flag[E_BACKUP];
    end
  end

  ecl_blink #(
    .FAST_HALF(FAST_HALF),
    .HALF_HALF(HALF_HALF),
    .SLOW_HALF(SLOW_HALF)
  ) u_blink (
    .clk(CLK_SYS),
    .rst(RST),
    .en(ERR_ACTIVE),
    .sel(blink_sel),
    .led(ERR_LED)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // A lone fault shows its code, class and period on the next cycle
  property p_alone(int idx, logic [CODE_W-1:0] code, logic hv, ecl_blink_t sel);
    (err_flag == (ONE_FLAG << idx)) |=> (ERR_CODE == code && ERR_HEAVY == hv && blink_sel == sel);
  endproperty

  sequence s_latched(int idx);
    err_flag[idx] ##1 ERR_FLAGS[idx];
  endsequence

  chk_pgm_report: assert property (PGM_BAD && RUN_SWITCH |=> s_latched(E_PGM))
    else $error("Corrupt program not latched at RUN entry");
  chk_pgm_code: assert property (p_alone(E_PGM, CODE_PGM, 1'b0, BLK_HALF))
    else $error("Corrupt program reported wrongly");
  chk_pgm_gate: assert property (!RUN_SWITCH && !err_flag[E_PGM] |=> !err_flag[E_PGM])
    else $error("Program check fired outside RUN entry");
  chk_ioprm_report: assert property (IOPRM_BAD && (RUN_SWITCH || CPU_RESET) |=> err_flag[E_IOPRM])
    else $error("I/O parameter fault not latched");
  chk_ioprm_code: assert property (p_alone(E_IOPRM, CODE_IOPRM, 1'b0, BLK_HALF))
    else $error("I/O parameter fault reported wrongly");
  chk_bprm_report: assert property (BPRM_BAD && (RUN_SWITCH || CPU_RESET) |=> err_flag[E_BPRM])
    else $error("Basic parameter fault not latched");
  chk_bprm_code: assert property (p_alone(E_BPRM, CODE_BPRM, 1'b0, BLK_HALF))
    else $error("Basic parameter fault reported wrongly");
  chk_mism_code: assert property (MOD_MISMATCH && RUN_SWITCH ##1 err_flag == (ONE_FLAG << E_MISM)
    |=> ERR_CODE == CODE_MISM && !ERR_HEAVY)
    else $error("Module mismatch reported wrongly");
  chk_modchg_code: assert property (p_alone(E_MODCHG, CODE_MODCHG, 1'b0, BLK_FAST))
    else $error("Module change reported wrongly");
  chk_modchg_scan: assert property (MOD_CHANGE && SCAN_START |=> err_flag[E_MODCHG])
    else $error("Module change missed at scan");
  chk_ioacc_code: assert property (p_alone(E_IOACC, CODE_IOACC, 1'b1, BLK_FAST))
    else $error("I/O access failure reported wrongly");
  chk_ioacc_end: assert property (IO_ACC_FAIL && SCAN_END |=> err_flag[E_IOACC])
    else $error("I/O access failure missed at scan end");
  chk_spacc_code: assert property (p_alone(E_SPACC, CODE_SPACC, 1'b1, BLK_FAST))
    else $error("Special module access failure reported wrongly");
  chk_cpu_any: assert property (CPU_FAULT |=> err_flag[E_CPU] ##1 ERR_HEAVY)
    else $error("Processor fault not raised as heavy");
  chk_cpu_code: assert property (p_alone(E_CPU, CODE_CPU, 1'b1, BLK_FAST))
    else $error("Processor fault reported wrongly");
  chk_wdt_code: assert property (p_alone(E_WDT, CODE_WDT, 1'b0, BLK_HALF))
    else $error("Scan watchdog reported wrongly");
  chk_wdt_run: assert property (SCAN_OVER && PGM_RUN |=> err_flag[E_WDT])
    else $error("Scan watchdog missed while running");
  chk_oper_code: assert property (p_alone(E_OPER, CODE_OPER, 1'b0, BLK_HALF))
    else $error("Operation error reported wrongly");
  chk_oper_idle: assert property (!PGM_RUN && !err_flag[E_OPER] |=> !err_flag[E_OPER])
    else $error("Operation error latched while not running");
  chk_tmr_code: assert property (p_alone(E_TMR, CODE_TMR, 1'b0, BLK_HALF))
    else $error("Timer index error reported wrongly");
  chk_ext_flag: assert property (EXT_HEAVY && SCAN_END |=> ##1 EXT_HEAVY_FLAG)
    else $error("External heavy flag not raised");
  chk_ext_code: assert property (p_alone(E_EXT, CODE_EXT, 1'b1, BLK_SLOW))
    else $error("External heavy fault reported wrongly");
  chk_estop_hold: assert property (err_flag[E_ESTOP] |=> err_flag[E_ESTOP])
    else $error("Emergency stop cleared without power cycle");
  chk_estop_code: assert property (p_alone(E_ESTOP, CODE_ESTOP, 1'b1, BLK_SLOW))
    else $error("Emergency stop reported wrongly");
  chk_backup_stop: assert property (err_flag[E_BACKUP] |=> FORCE_STOP)
    else $error("Backup failure did not force STOP");
  chk_backup_code: assert property (p_alone(E_BACKUP, CODE_BACKUP, 1'b0, BLK_SLOW))
    else $error("Backup failure reported wrongly");
  chk_backup_late: assert property (!por_chk && !err_flag[E_BACKUP] |=> !err_flag[E_BACKUP])
    else $error("Backup failure latched after power-on");
  chk_heavy_wins: assert property ((err_flag & HEAVY_MASK) != '0 |=> ERR_HEAVY
    && ERR_CODE != CODE_NONE)
    else $error("Heavy error did not take precedence");
  chk_warn_only: assert property ((err_flag & HEAVY_MASK) == '0 && err_flag != '0
    |=> !ERR_HEAVY && ERR_ACTIVE)
    else $error("Warning reported as heavy");
endmodule : ecl_top
`default_nettype wire

// file: tb/ecl_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ecl_top_bench
  import ecl_pkg::*;
;
  localparam int FH = 4;
  localparam int HH = 10;
  localparam int SH = 20;
  localparam int LIMIT = 5000;

  typedef struct {
    int slot;
    int cp;
    logic [CODE_W-1:0] code;
    logic heavy;
    int half;
  } ecl_row_t;

  // Check point index: 0..4 strobe bits of cpv, 5 none needed, 6 power-on window
  ecl_row_t rows [NERR] = '{
    '{0, 0, 10'h017, 1'b0, HH},
    '{1, 1, 10'h018, 1'b0, HH},
    '{2, 6, 10'h019, 1'b0, HH},
    '{3, 0, 10'h01e, 1'b0, HH},
    '{4, 2, 10'h01f, 1'b0, FH},
    '{5, 3, 10'h021, 1'b1, FH},
    '{6, 3, 10'h022, 1'b1, FH},
    '{7, 5, 10'h027, 1'b1, FH},
    '{8, 4, 10'h028, 1'b0, HH},
    '{9, 4, 10'h029, 1'b0, HH},
    '{10, 3, 10'h02c, 1'b0, HH},
    '{11, 3, 10'h032, 1'b1, SH},
    '{12, 4, 10'h03c, 1'b1, SH},
    '{13, 6, 10'h1f4, 1'b0, SH}
  };

  logic clk_sys;
  logic rst;
  logic clr_err;
  logic [4:0] cpv;
  logic [NERR-1:0] fv;
  logic [CODE_W-1:0] err_code;
  logic err_heavy;
  logic err_active;
  logic err_led;
  logic [NERR-1:0] err_flags;
  logic ext_heavy_flag;
  logic force_stop;
  int n_errors;
  int comparisons;
  int cycles;

  ecl_top #(.FAST_HALF(FH), .HALF_HALF(HH), .SLOW_HALF(SH)) ecl_top_i (
    .CLK_SYS(clk_sys), .RST(rst),
    .RUN_SWITCH(cpv[0]), .CPU_RESET(cpv[1]), .SCAN_START(cpv[2]), .SCAN_END(cpv[3]), .PGM_RUN(cpv[4]),
    .PGM_BAD(fv[0]), .IOPRM_BAD(fv[1]), .BPRM_BAD(fv[2]), .MOD_MISMATCH(fv[3]), .MOD_CHANGE(fv[4]),
    .IO_ACC_FAIL(fv[5]), .SPL_ACC_FAIL(fv[6]), .CPU_FAULT(fv[7]), .SCAN_OVER(fv[8]), .OPER_ERR(fv[9]),
    .TMR_IDX_ERR(fv[10]), .EXT_HEAVY(fv[11]), .ESTOP_EXEC(fv[12]), .BACKUP_FAIL(fv[13]),
    .CLR_ERR(clr_err),
    .ERR_CODE(err_code), .ERR_HEAVY(err_heavy), .ERR_ACTIVE(err_active), .ERR_LED(err_led),
    .ERR_FLAGS(err_flags), .EXT_HEAVY_FLAG(ext_heavy_flag), .FORCE_STOP(force_stop)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      results();
    end
  end

  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask : step

  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("code %h expected %h", got, exp));
  endtask : chk_code

  task automatic chk_flags(input logic [NERR-1:0] got, input logic [NERR-1:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("flags %h expected %h", got, exp));
  endtask : chk_flags

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) fail($sformatf("%s is %b expected %b", what, got, exp));
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) fail($sformatf("LED lit %0d cycles expected %0d", got, exp));
  endtask : chk_cnt

  // Faults in por are held across the first cycles after release
  task automatic do_reset(input int n, input logic [NERR-1:0] por);
    rst = 1'b1;
    fv = por;
    cpv = '0;
    clr_err = 1'b0;
    repeat (n) step();
    rst = 1'b0;
    step();
    step();
    fv = '0;
  endtask : do_reset

  // Raise faults with one check point strobe, then wait out the two-cycle latency
  task automatic fire(input logic [NERR-1:0] m, input int cp);
    fv = m;
    if (cp < 5) cpv[cp] = 1'b1;
    step();
    fv = '0;
    cpv = '0;
    step();
    step();
  endtask : fire

  task automatic measure_led(output int n);
    int k;
    n = 0;
    k = 0;
    while (err_led !== 1'b1 && k < 100) begin
      step();
      k++;
    end
    while (err_led === 1'b1 && n < 1000) begin
      step();
      n++;
    end
  endtask : measure_led

  initial begin
    logic [NERR-1:0] oh;
    int n;
    rst = 1'b1;
    clr_err = 1'b0;
    cpv = '0;
    fv = '0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    do_reset(8, '0);
    step();
    chk_code(err_code, 10'h000);
    chk_flags(err_flags, '0);
    chk_bit(err_active, 1'b0, "active");
    chk_bit(err_led, 1'b0, "led");
    foreach (rows[r]) begin
      oh = ONE_FLAG << rows[r].slot;
      if (rows[r].cp == 6) begin
        do_reset(2, oh);
        step();
      end else begin
        do_reset(2, '0);
        fire(oh, rows[r].cp);
      end
      chk_code(err_code, rows[r].code);
      chk_bit(err_heavy, rows[r].heavy, "heavy");
      chk_bit(err_active, 1'b1, "active");
      chk_flags(err_flags, oh);
      chk_bit(ext_heavy_flag, rows[r].slot == 11, "ext flag");
      chk_bit(force_stop, rows[r].slot == 13, "force stop");
      measure_led(n);
      chk_cnt(n, rows[r].half);
    end
    // Faults outside their check point leave nothing behind
    do_reset(2, '0);
    fire(14'h0001, 3);
    fire(14'h0010, 3);
    fire(14'h2000, 0);
    fire(14'h0300, 3);
    chk_flags(err_flags, '0);
    // Lowest warning wins, any heavy beats warnings
    fire(14'h0200, 4);
    fire(14'h0100, 4);
    chk_code(err_code, 10'h028);
    fire(14'h0001, 0);
    chk_code(err_code, 10'h017);
    fire(14'h0040, 3);
    chk_code(err_code, 10'h022);
    chk_bit(err_heavy, 1'b1, "heavy");
    measure_led(n);
    chk_cnt(n, FH);
    fire(14'h0020, 3);
    chk_code(err_code, 10'h021);
    // Operator clear keeps power-cycle faults; a new fault beats the clear
    fire(14'h0080, 5);
    fire(14'h1000, 4);
    clr_err = 1'b1;
    fv = 14'h0001;
    cpv[0] = 1'b1;
    step();
    clr_err = 1'b0;
    fv = '0;
    cpv = '0;
    step();
    step();
    chk_flags(err_flags, 14'h1081);
    chk_code(err_code, 10'h027);
    do_reset(2, '0);
    step();
    chk_flags(err_flags, '0);
    chk_bit(err_led, 1'b0, "led");
    results();
  end
endmodule : ecl_top_bench
`default_nettype wire
